// ===== inc/insn_pkg.sv
// Purpose: constants for the move/literal/indirect-store/return instruction executor
// Assumes: 14-bit instruction words, 8-bit data path, 16-bit pointers
// Notes: register port offsets index 8-bit registers
// Function
// - bank select load copies 6-bit literal into the bank select register
// - pc high latch load writes 7-bit literal, flags unchanged
// - accumulator literal load puts 8-bit literal into accumulator, one cycle
// - accumulator-to-file move writes accumulator to file address, one cycle
// - indirect store writes accumulator via one of two pointers, no flags
// - update code: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - pre modes address pointer plus/minus one and keep the updated pointer
// - post modes address current pointer, then step it by one
// - relative form addresses pointer plus signed offset, pointer unchanged
// - pointers span 0000h to ffffh and wrap modulo 16 bits
// - pointer stepping never touches any status bit
// - software reset triggers a full reset like other reset sources; pc_value_r, file_addr_r and file_wdata_r keep their values here
// - return from interrupt pops the stack and loads stack top into pc
// - return from interrupt sets the global interrupt enable, control bit 7
// - return from interrupt takes two cycles and changes no flag
package insn_pkg;
	typedef enum logic [3:0] {
		OP_IDLE, OP_SWRESET, OP_RETIRQ, OP_LDBANK, OP_LDPCH, OP_LDACC,
		OP_STFILE, OP_STIND, OP_STREL, OP_OTHER
	} op_t;

	// opcode patterns and masks
	localparam logic [13:0] ENC_IDLE = 14'h0000;
	localparam logic [13:0] ENC_SWRESET = 14'h0001;
	localparam logic [13:0] ENC_RETIRQ = 14'h0009;
	localparam logic [13:0] ENC_STIND = 14'h0010;
	localparam logic [13:0] MSK_STIND = 14'h3ff8;
	localparam logic [13:0] ENC_LDBANK = 14'h0140;
	localparam logic [13:0] MSK_LDBANK = 14'h3fc0;
	localparam logic [13:0] ENC_STFILE = 14'h0080;
	localparam logic [13:0] MSK_STFILE = 14'h3f80;
	localparam logic [13:0] ENC_LDACC = 14'h3000;
	localparam logic [13:0] MSK_LDACC = 14'h3f00;
	localparam logic [13:0] ENC_LDPCH = 14'h3180;
	localparam logic [13:0] MSK_LDPCH = 14'h3f80;
	localparam logic [13:0] ENC_STREL = 14'h3f80;
	localparam logic [13:0] MSK_STREL = 14'h3f80;

	// field positions
	localparam int SEL_BIT_IND = 2;
	localparam int SEL_BIT_REL = 6;
	localparam logic [1:0] UPD_PRE_INC = 2'h0;
	localparam logic [1:0] UPD_PRE_DEC = 2'h1;
	localparam logic [1:0] UPD_POST_INC = 2'h2;
	localparam logic [1:0] UPD_POST_DEC = 2'h3;
	localparam int GIE_BIT = 7;

	// register port offsets
	localparam logic [3:0] OFS_ACC = 4'h0;
	localparam logic [3:0] OFS_BANK = 4'h1;
	localparam logic [3:0] OFS_PCH = 4'h2;
	localparam logic [3:0] OFS_IRQCTL = 4'h3;
	localparam logic [3:0] OFS_PTR0_LO = 4'h4;
	localparam logic [3:0] OFS_PTR0_HI = 4'h5;
	localparam logic [3:0] OFS_PTR1_LO = 4'h6;
	localparam logic [3:0] OFS_PTR1_HI = 4'h7;
	localparam logic [3:0] OFS_STATE = 4'h8;

	// reset values
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [5:0] RST_BANK = 6'h00;
	localparam logic [6:0] RST_PCH = 7'h00;
	localparam logic [7:0] RST_IRQCTL = 8'h00;
	localparam logic [15:0] RST_PTR = 16'h0000;

	// cycles taken by the two-cycle return
	localparam int RET_CYCLES = 2;
endpackage

// ===== logic/pointer_unit.sv
// Purpose: one 16-bit indirect pointer with byte writes and +/-1 stepping
// Assumes: step and byte writes are single-cycle requests
// Notes: step wins over a same-cycle byte write from the register port
`timescale 1ns/1ps
module pointer_unit (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic clr,
	// register port writes
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	// stepping
	input wire logic step,
	input wire logic down,
	// value
	output logic [15:0] ptr_r
);
	logic [15:0] ptr_nxt;

	always_comb begin
		ptr_nxt = ptr_r;
		if (step) begin
			// plain 16-bit add/sub wraps both ends; no flag is produced
			ptr_nxt = down ? 16'(ptr_r - 16'h0001) : 16'(ptr_r + 16'h0001);
		end else if (wr_lo) begin
			ptr_nxt = {ptr_r[15:8], wdata};
		end else if (wr_hi) begin
			ptr_nxt = {wdata, ptr_r[7:0]};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= insn_pkg::RST_PTR;
		end else if (ce) begin
			ptr_r <= clr ? insn_pkg::RST_PTR : ptr_nxt;
		end
	end
endmodule

// ===== logic/insn_exec.sv
// Purpose: executes literal loads, accumulator stores, indirect store, idle, software reset and return
// Assumes: one instruction offered per cycle while ins_ready_r is high; stack and file are outside
// Notes: all other opcodes are ignored here; the status register is never driven by this block
`timescale 1ns/1ps
module insn_exec (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// instruction stream
	input wire logic ins_valid,
	input wire logic [13:0] ins_word,
	output logic ins_ready_r,
	// stack and program counter
	input wire logic [14:0] stack_top,
	output logic stack_pop_r,
	output logic pc_load_r,
	output logic [14:0] pc_value_r,
	// file register write
	output logic file_we_r,
	output logic [15:0] file_addr_r,
	output logic [7:0] file_wdata_r,
	// core state
	output logic [7:0] acc_r,
	output logic [5:0] bank_r,
	output logic [6:0] pc_high_r,
	output logic gie_r,
	output logic sw_reset_r,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r
);
	typedef enum logic {ST_RUN, ST_RET2} state_t;

	state_t state_r;
	state_t state_nxt;
	insn_pkg::op_t op;
	logic exec;
	logic clr;
	logic sel;
	logic [1:0] upd;
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [15:0] ptr_sel;
	logic [15:0] eff_addr;
	logic [15:0] rel_off;
	logic [1:0] step_en;
	logic step_down;
	logic [6:0] irq_low_r;
	logic [7:0] rd_nxt;

	// decode
	always_comb begin
		if (ins_word == insn_pkg::ENC_IDLE) op = insn_pkg::OP_IDLE;
		else if (ins_word == insn_pkg::ENC_SWRESET) op = insn_pkg::OP_SWRESET;
		else if (ins_word == insn_pkg::ENC_RETIRQ) op = insn_pkg::OP_RETIRQ;
		else if ((ins_word & insn_pkg::MSK_STIND) == insn_pkg::ENC_STIND) op = insn_pkg::OP_STIND;
		else if ((ins_word & insn_pkg::MSK_LDBANK) == insn_pkg::ENC_LDBANK) op = insn_pkg::OP_LDBANK;
		else if ((ins_word & insn_pkg::MSK_STFILE) == insn_pkg::ENC_STFILE) op = insn_pkg::OP_STFILE;
		else if ((ins_word & insn_pkg::MSK_LDACC) == insn_pkg::ENC_LDACC) op = insn_pkg::OP_LDACC;
		else if ((ins_word & insn_pkg::MSK_LDPCH) == insn_pkg::ENC_LDPCH) op = insn_pkg::OP_LDPCH;
		else if ((ins_word & insn_pkg::MSK_STREL) == insn_pkg::ENC_STREL) op = insn_pkg::OP_STREL;
		else op = insn_pkg::OP_OTHER;
	end

	assign exec = ce && ins_valid && ins_ready_r;
	assign clr = exec && (op == insn_pkg::OP_SWRESET);

	// pointer selection and effective address
	assign sel = (op == insn_pkg::OP_STREL) ? ins_word[insn_pkg::SEL_BIT_REL] : ins_word[insn_pkg::SEL_BIT_IND];
	assign upd = ins_word[1:0];
	assign ptr_sel = sel ? ptr1 : ptr0;
	assign rel_off = {{10{ins_word[5]}}, ins_word[5:0]};

	always_comb begin
		eff_addr = ptr_sel;
		step_down = 1'b0;
		if (op == insn_pkg::OP_STREL) begin
			eff_addr = 16'(ptr_sel + rel_off);
		end else begin
			case (upd)
				insn_pkg::UPD_PRE_INC: eff_addr = 16'(ptr_sel + 16'h0001);
				insn_pkg::UPD_PRE_DEC: begin
					eff_addr = 16'(ptr_sel - 16'h0001);
					step_down = 1'b1;
				end
				insn_pkg::UPD_POST_INC: eff_addr = ptr_sel;
				insn_pkg::UPD_POST_DEC: begin
					eff_addr = ptr_sel;
					step_down = 1'b1;
				end
				default: eff_addr = ptr_sel;
			endcase
		end
	end

	// every update mode steps the pointer; the relative form leaves it alone
	always_comb begin
		step_en = 2'b00;
		if (exec && op == insn_pkg::OP_STIND) begin
			step_en[sel] = 1'b1;
		end
	end

	pointer_unit u_ptr0 (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.clr(clr),
		.wr_lo(reg_wr && reg_addr == insn_pkg::OFS_PTR0_LO),
		.wr_hi(reg_wr && reg_addr == insn_pkg::OFS_PTR0_HI),
		.wdata(reg_wdata),
		.step(step_en[0]),
		.down(step_down),
		.ptr_r(ptr0)
	);

	pointer_unit u_ptr1 (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.clr(clr),
		.wr_lo(reg_wr && reg_addr == insn_pkg::OFS_PTR1_LO),
		.wr_hi(reg_wr && reg_addr == insn_pkg::OFS_PTR1_HI),
		.wdata(reg_wdata),
		.step(step_en[1]),
		.down(step_down),
		.ptr_r(ptr1)
	);

	// return sequencing: second cycle refuses new instructions
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: if (exec && op == insn_pkg::OP_RETIRQ) state_nxt = ST_RET2;
			ST_RET2: state_nxt = ST_RUN;
			default: state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_RUN;
			ins_ready_r <= 1'b1;
		end else if (ce) begin
			state_r <= clr ? ST_RUN : state_nxt;
			ins_ready_r <= clr || (state_nxt == ST_RUN);
		end
	end

	// stack pop and program counter load
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stack_pop_r <= 1'b0;
			pc_load_r <= 1'b0;
			pc_value_r <= 15'h0000;
		end else if (ce) begin
			stack_pop_r <= exec && op == insn_pkg::OP_RETIRQ;
			pc_load_r <= exec && op == insn_pkg::OP_RETIRQ;
			if (exec && op == insn_pkg::OP_RETIRQ) pc_value_r <= stack_top;
		end
	end

	// file writes: direct and indirect
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			file_we_r <= 1'b0;
			file_addr_r <= 16'h0000;
			file_wdata_r <= 8'h00;
		end else if (ce) begin
			file_we_r <= 1'b0;
			if (exec && op == insn_pkg::OP_STFILE) begin
				file_we_r <= 1'b1;
				file_addr_r <= {3'h0, bank_r, ins_word[6:0]};
				file_wdata_r <= acc_r;
			end else if (exec && (op == insn_pkg::OP_STIND || op == insn_pkg::OP_STREL)) begin
				file_we_r <= 1'b1;
				file_addr_r <= eff_addr;
				file_wdata_r <= acc_r;
			end
		end
	end

	// accumulator: instruction wins over a same-cycle port write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_r <= insn_pkg::RST_ACC;
		end else if (ce) begin
			if (clr) acc_r <= insn_pkg::RST_ACC;
			else if (exec && op == insn_pkg::OP_LDACC) acc_r <= ins_word[7:0];
			else if (reg_wr && reg_addr == insn_pkg::OFS_ACC) acc_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bank_r <= insn_pkg::RST_BANK;
		end else if (ce) begin
			if (clr) bank_r <= insn_pkg::RST_BANK;
			else if (exec && op == insn_pkg::OP_LDBANK) bank_r <= ins_word[5:0];
			else if (reg_wr && reg_addr == insn_pkg::OFS_BANK) bank_r <= reg_wdata[5:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_high_r <= insn_pkg::RST_PCH;
		end else if (ce) begin
			if (clr) pc_high_r <= insn_pkg::RST_PCH;
			else if (exec && op == insn_pkg::OP_LDPCH) pc_high_r <= ins_word[6:0];
			else if (reg_wr && reg_addr == insn_pkg::OFS_PCH) pc_high_r <= reg_wdata[6:0];
		end
	end

	// interrupt control: the return's set wins over a software clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gie_r <= insn_pkg::RST_IRQCTL[insn_pkg::GIE_BIT];
			irq_low_r <= insn_pkg::RST_IRQCTL[6:0];
		end else if (ce) begin
			if (clr) begin
				gie_r <= insn_pkg::RST_IRQCTL[insn_pkg::GIE_BIT];
				irq_low_r <= insn_pkg::RST_IRQCTL[6:0];
			end else begin
				if (reg_wr && reg_addr == insn_pkg::OFS_IRQCTL) begin
					gie_r <= reg_wdata[insn_pkg::GIE_BIT];
					irq_low_r <= reg_wdata[6:0];
				end
				if (exec && op == insn_pkg::OP_RETIRQ) gie_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sw_reset_r <= 1'b0;
		end else if (ce) begin
			sw_reset_r <= clr;
		end
	end

	// register port read, data valid only in the following cycle
	always_comb begin
		case (reg_addr)
			insn_pkg::OFS_ACC: rd_nxt = acc_r;
			insn_pkg::OFS_BANK: rd_nxt = {2'h0, bank_r};
			insn_pkg::OFS_PCH: rd_nxt = {1'b0, pc_high_r};
			insn_pkg::OFS_IRQCTL: rd_nxt = {gie_r, irq_low_r};
			insn_pkg::OFS_PTR0_LO: rd_nxt = ptr0[7:0];
			insn_pkg::OFS_PTR0_HI: rd_nxt = ptr0[15:8];
			insn_pkg::OFS_PTR1_LO: rd_nxt = ptr1[7:0];
			insn_pkg::OFS_PTR1_HI: rd_nxt = ptr1[15:8];
			insn_pkg::OFS_STATE: rd_nxt = {7'h00, state_r == ST_RET2};
			default: rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_r <= 8'h00;
		end else if (ce) begin
			reg_rdata_r <= reg_rd ? rd_nxt : 8'h00;
		end
	end

	// checks
	property p_ldbank;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_LDBANK |=> bank_r == $past(ins_word[5:0]) && ins_ready_r;
	endproperty
	a_ldbank: assert property (p_ldbank) else $error("bank load mismatch");

	property p_ldpch;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_LDPCH |=> pc_high_r == $past(ins_word[6:0]) && $stable(acc_r);
	endproperty
	a_ldpch: assert property (p_ldpch) else $error("pc high load mismatch");

	property p_ldacc;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_LDACC |=> acc_r == $past(ins_word[7:0]) && ins_ready_r && !file_we_r;
	endproperty
	a_ldacc: assert property (p_ldacc) else $error("accumulator load mismatch");

	property p_stfile;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_STFILE |=> file_we_r && file_wdata_r == $past(acc_r)
			&& file_addr_r[6:0] == $past(ins_word[6:0]) && file_addr_r[12:7] == $past(bank_r);
	endproperty
	a_stfile: assert property (p_stfile) else $error("file store mismatch");

	property p_postinc0;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_STIND && !sel && upd == insn_pkg::UPD_POST_INC
			|=> file_addr_r == $past(ptr0) && ptr0 == 16'($past(ptr0) + 16'h0001);
	endproperty
	a_postinc0: assert property (p_postinc0) else $error("post increment mismatch");

	property p_predec1;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_STIND && sel && upd == insn_pkg::UPD_PRE_DEC
			|=> file_addr_r == ptr1 && ptr1 == 16'($past(ptr1) - 16'h0001) && $stable(ptr0);
	endproperty
	a_predec1: assert property (p_predec1) else $error("pre decrement mismatch");

	property p_rel;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_STREL |=> $stable(ptr0) && $stable(ptr1) && file_we_r;
	endproperty
	a_rel: assert property (p_rel) else $error("relative store moved a pointer");

	sequence s_ret_first;
		stack_pop_r && pc_load_r && gie_r && !ins_ready_r;
	endsequence
	sequence s_ret_second;
		!stack_pop_r && ins_ready_r;
	endsequence
	property p_retirq;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_RETIRQ ##1 ce |-> s_ret_first ##1 s_ret_second;
	endproperty
	a_retirq: assert property (p_retirq) else $error("return from interrupt sequence wrong");

	property p_swreset;
		@(posedge clk) disable iff (!nrst)
		clr |=> sw_reset_r && acc_r == insn_pkg::RST_ACC && ptr0 == insn_pkg::RST_PTR && !gie_r;
	endproperty
	a_swreset: assert property (p_swreset) else $error("software reset incomplete");

	property p_idle;
		@(posedge clk) disable iff (!nrst)
		exec && op == insn_pkg::OP_IDLE && !reg_wr |=> $stable(acc_r) && $stable(bank_r) && !file_we_r;
	endproperty
	a_idle: assert property (p_idle) else $error("idle op changed state");
endmodule

// ===== tb/stack_model.sv
// Purpose: hardware stack partner that answers return pops for the executor
// Assumes: two preloaded return addresses, popped one per stack_pop pulse
// Notes: when empty, stack_top toggles every cycle so a late sample never looks valid
`timescale 1ns/1ps
module stack_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// pop request
	input wire logic pop,
	// popped value
	output logic [14:0] top
);
	logic [1:0] depth_r;
	logic [14:0] junk_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			depth_r <= 2'h2;
			junk_r <= 15'h2aaa;
		end else begin
			junk_r <= ~junk_r;
			if (pop && depth_r != 2'h0) begin
				depth_r <= depth_r - 2'h1;
			end
		end
	end

	always_comb begin
		case (depth_r)
			2'h2: top = 15'h7abc;
			2'h1: top = 15'h0123;
			default: top = junk_r;
		endcase
	end
endmodule

// ===== tb/tb_move_literal_indirect_return_ops.sv
// Purpose: self-checking bench for the instruction executor
// Assumes: 25 MHz clock, outputs sampled 1 ns after the edge that updates them
// Notes: pointer wrap is exercised at both ends of the 16-bit range
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_move_literal_indirect_return_ops;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic ins_valid = 1'b0;
	logic [13:0] ins_word = 14'h0000;
	logic [14:0] stack_top;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ins_ready_r, stack_pop_r, pc_load_r, file_we_r, gie_r, sw_reset_r;
	logic [14:0] pc_value_r;
	logic [15:0] file_addr_r;
	logic [7:0] file_wdata_r, acc_r, reg_rdata_r;
	logic [5:0] bank_r;
	logic [6:0] pc_high_r;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;

	always #20 clk = ~clk;

	insn_exec DUT (.clk(clk), .nrst(nrst), .ce(ce), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_ready_r(ins_ready_r), .stack_top(stack_top), .stack_pop_r(stack_pop_r), .pc_load_r(pc_load_r),
		.pc_value_r(pc_value_r), .file_we_r(file_we_r), .file_addr_r(file_addr_r), .file_wdata_r(file_wdata_r),
		.acc_r(acc_r), .bank_r(bank_r), .pc_high_r(pc_high_r), .gie_r(gie_r), .sw_reset_r(sw_reset_r),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

	stack_model stack (.clk(clk), .nrst(nrst), .pop(stack_pop_r), .top(stack_top));

	task automatic end_sim;
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog: a hung sequence is cut off and reported
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic exec(input logic [13:0] w);
		@(posedge clk);
		ins_valid <= 1'b1;
		ins_word <= w;
		@(posedge clk);
		ins_valid <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_r;
	endtask

	task automatic t_literals;
		logic [7:0] d;
		exec(14'h0140 | 14'h003f);
		exec(14'h3180 | 14'h007f);
		exec(14'h3000 | 14'h00a5);
		`CHK(bank_r, 6'h3f)
		`CHK(pc_high_r, 7'h7f)
		`CHK(acc_r, 8'ha5)
		exec(14'h0140 | 14'h0012);
		`CHK(bank_r, 6'h12)
		rd(insn_pkg::OFS_ACC, d);
		`CHK(d, 8'ha5)
		rd(4'h9, d);
		`CHK(d, 8'h00)
	endtask

	task automatic t_file_store;
		exec(14'h0080 | 14'h007f);
		`CHK(file_we_r, 1'b1)
		`CHK(file_addr_r, {3'h0, 6'h12, 7'h7f})
		`CHK(file_wdata_r, 8'ha5)
		@(posedge clk);
		#1;
		`CHK(file_we_r, 1'b0)
	endtask

	task automatic t_indirect;
		logic [15:0] p, np, ea;
		logic [7:0] lo, hi;
		for (int n = 0; n < 2; n++) begin
			for (int m = 0; m < 4; m++) begin
				// increments start at the top and decrements at zero to force wrap
				p = m[0] ? 16'h0000 : 16'hffff;
				wr(insn_pkg::OFS_PTR0_LO + 4'(2 * n), p[7:0]);
				wr(insn_pkg::OFS_PTR0_HI + 4'(2 * n), p[15:8]);
				np = m[0] ? p - 16'h0001 : p + 16'h0001;
				ea = m[1] ? p : np;
				exec(14'h0010 | 14'(n << 2) | 14'(m));
				`CHK(file_we_r, 1'b1)
				`CHK(file_addr_r, ea)
				`CHK(file_wdata_r, 8'ha5)
				rd(insn_pkg::OFS_PTR0_LO + 4'(2 * n), lo);
				rd(insn_pkg::OFS_PTR0_HI + 4'(2 * n), hi);
				`CHK({hi, lo}, np)
			end
		end
	endtask

	task automatic t_relative;
		logic [7:0] lo, hi;
		wr(insn_pkg::OFS_PTR1_LO, 8'h10);
		wr(insn_pkg::OFS_PTR1_HI, 8'h20);
		exec(14'h3f80 | 14'h0040 | 14'h0020);
		`CHK(file_addr_r, 16'h2010 - 16'h0020)
		exec(14'h3f80 | 14'h0040 | 14'h001f);
		`CHK(file_addr_r, 16'h2010 + 16'h001f)
		rd(insn_pkg::OFS_PTR1_LO, lo);
		rd(insn_pkg::OFS_PTR1_HI, hi);
		`CHK({hi, lo}, 16'h2010)
	endtask

	task automatic t_return(input logic [14:0] exp_pc);
		logic [7:0] d;
		wr(insn_pkg::OFS_IRQCTL, 8'h00);
		@(posedge clk);
		ins_valid <= 1'b1;
		ins_word <= 14'h0009;
		@(posedge clk);
		// offered in the dead cycle, must be ignored
		ins_word <= 14'h3033;
		reg_rd <= 1'b1;
		reg_addr <= insn_pkg::OFS_STATE;
		#1;
		`CHK(stack_pop_r, 1'b1)
		`CHK(pc_load_r, 1'b1)
		`CHK(pc_value_r, exp_pc)
		`CHK(gie_r, 1'b1)
		`CHK(ins_ready_r, 1'b0)
		@(posedge clk);
		ins_valid <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata_r, 8'h01)
		`CHK(stack_pop_r, 1'b0)
		`CHK(ins_ready_r, 1'b1)
		`CHK(acc_r, 8'ha5)
		rd(insn_pkg::OFS_IRQCTL, d);
		`CHK(d[insn_pkg::GIE_BIT], 1'b1)
	endtask

	task automatic t_idle;
		exec(14'h0000);
		`CHK({acc_r, bank_r, pc_high_r, file_we_r}, {8'ha5, 6'h12, 7'h7f, 1'b0})
		@(posedge clk);
		ce <= 1'b0;
		exec(14'h3000 | 14'h0011);
		`CHK(acc_r, 8'ha5)
		@(posedge clk);
		ce <= 1'b1;
	endtask

	task automatic t_sw_reset;
		logic [7:0] d;
		exec(14'h0001);
		`CHK(sw_reset_r, 1'b1)
		`CHK({acc_r, bank_r, pc_high_r, gie_r}, 22'h000000)
		rd(insn_pkg::OFS_PTR1_HI, d);
		`CHK(d, 8'h00)
		`CHK(sw_reset_r, 1'b0)
	endtask

	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		`CHK(ins_ready_r, 1'b1)
		t_literals();
		t_file_store();
		t_indirect();
		t_relative();
		t_return(15'h7abc);
		t_return(15'h0123);
		t_idle();
		t_sw_reset();
		end_sim();
	end
endmodule
